/* File: sim/pfsa_ctrl_assertions.sv */
// pfsa_ctrl_assertions: port-level checker for the flash self-access controller.
// assumes CE stays high while the bus is in use.
`timescale 1ns/1ps
`default_nettype none
module pfsa_ctrl_assertions #(
    parameter int unsigned ERASE_COUNT = 16
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // bus
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    // config and core side
    input wire logic CODE_PROTECT_B,
    input wire logic CPU_HALT,
    input wire logic PROGRAMMER_ALLOW
);
    import pfsa_pkg::*;
    logic [31:0] halt_cnt_q;
    logic [31:0] halt_cnt_d;
    // counter, since the halt is far too long for a repetition
    always_comb halt_cnt_d = CPU_HALT ? halt_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) halt_cnt_q <= 32'h0;
        else halt_cnt_q <= halt_cnt_d;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    bvalid_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    // capture edge, execute edge, then the response is visible
    write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY && !BVALID |-> ##2 BVALID)
        else $error("write answer late");
    programmer_gate_a: assert property (PROGRAMMER_ALLOW == CODE_PROTECT_B)
        else $error("programmer gate wrong");
    halt_len_a: assert property (!CPU_HALT && halt_cnt_q != 32'h0 |-> halt_cnt_q == ERASE_COUNT)
        else $error("halt length wrong");
    slverr_zero_a: assert property (RVALID && RRESP == RESP_SLVERR |-> RDATA == 32'h0)
        else $error("error read not zero");
    key_read_zero_a: assert property (ARVALID && ARREADY && ARADDR == OFS_UNLOCK |=> RDATA == 32'h0)
        else $error("unlock key read not zero");
    ctl_upper_a: assert property (ARVALID && ARREADY && ARADDR == OFS_CONTROL |=> RDATA[31:3] == 29'h0)
        else $error("control upper bits set");
    cover property ($rose(CPU_HALT));
    cover property (RVALID && RRESP == RESP_SLVERR);
    cover property (BVALID && BREADY && !PROGRAMMER_ALLOW);
endmodule : pfsa_ctrl_assertions
bind pfsa_ctrl pfsa_ctrl_assertions #(.ERASE_COUNT(ERASE_COUNT)) i_pfsa_ctrl_assertions (
    .CLK(CLK), .RST_B(RST_B), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .CODE_PROTECT_B(CODE_PROTECT_B), .CPU_HALT(CPU_HALT),
    .PROGRAMMER_ALLOW(PROGRAMMER_ALLOW));
`default_nettype wire

/* File: sim/pfsa_ctrl_test.sv */
// pfsa_ctrl_test: random and corner-case bench for the flash self-access controller.
// assumes config inputs change only under reset and the array keeps data across reset.
`timescale 1ns/1ps
`default_nettype none
module pfsa_ctrl_test;
    import pfsa_pkg::*;
    logic CLK, RST_B, CE, AWVALID, WVALID, BVALID, BREADY, ARVALID, RVALID, RREADY;
    logic AWREADY, WREADY, ARREADY, CODE_PROTECT_B, CPU_HALT, PROGRAMMER_ALLOW;
    logic [7:0] AWADDR, ARADDR, v;
    logic [31:0] WDATA, RDATA, rv;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, WRITE_PROTECT_SELECT, rs;
    logic [31:0] rng = 32'h0001765A;
    // lag holds the response ready back until the answer shows, to stretch it
    logic lag = 1'b0;
    logic [7:0] offs [6] = '{OFS_DATA_LOW, OFS_ADDR_LOW, OFS_DATA_HIGH, OFS_ADDR_HIGH,
        OFS_CONTROL, OFS_UNLOCK};
    logic [7:0] msk [4] = '{8'hFF, 8'hFF, 8'h3F, 8'h03};
    int n_mismatch = 0;
    int checks = 0;
    // short erase so the run stays brief
    pfsa_ctrl #(.ERASE_COUNT(16)) i_pfsa_ctrl (.CLK(CLK), .RST_B(RST_B), .CE(CE),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .WRITE_PROTECT_SELECT(WRITE_PROTECT_SELECT),
        .CODE_PROTECT_B(CODE_PROTECT_B), .CPU_HALT(CPU_HALT), .PROGRAMMER_ALLOW(PROGRAMMER_ALLOW));
    pfsa_flash_ref i_pfsa_flash_ref ();
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic guard(input int n);
        if (n > 40) begin
            n_mismatch++;
            conclude();
        end
    endtask : guard
    // readies sampled mid-cycle, so the edge after is the transfer edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        logic ta, tw, tb, tv;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= {24'h0, d};
        {AWVALID, WVALID, BREADY} <= {2'h3, !lag};
        n = 0;
        tb = 1'b0;
        while (!tb) begin
            @(negedge CLK);
            ta = AWVALID && AWREADY;
            tw = WVALID && WREADY;
            tb = BVALID && BREADY;
            tv = BVALID;
            rs = BRESP;
            @(posedge CLK);
            if (ta) AWVALID <= 1'b0;
            if (tw) WVALID <= 1'b0;
            if (tv && !tb) BREADY <= 1'b1;
            n++;
            guard(n);
        end
        BREADY <= 1'b0;
        chk("bresp", {30'h0, rs}, {30'h0, (a > OFS_UNLOCK) ? RESP_SLVERR : RESP_OKAY});
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        logic ta, tr, tv;
        @(posedge CLK);
        ARADDR <= a;
        {ARVALID, RREADY} <= {1'b1, !lag};
        n = 0;
        tr = 1'b0;
        while (!tr) begin
            @(negedge CLK);
            ta = ARVALID && ARREADY;
            tr = RVALID && RREADY;
            tv = RVALID;
            rv = RDATA;
            rs = RRESP;
            @(posedge CLK);
            if (ta) ARVALID <= 1'b0;
            if (tv && !tr) RREADY <= 1'b1;
            n++;
            guard(n);
        end
        RREADY <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), rv, e);
    endtask : rc
    task automatic fread(input logic [9:0] a);
        logic [7:0] w;
        wr(OFS_ADDR_HIGH, {6'h0, a[9:8]});
        wr(OFS_ADDR_LOW, a[7:0]);
        wr(OFS_CONTROL, 8'h05);
        repeat (3) @(posedge CLK);
        rd(OFS_DATA_LOW);
        w = rv[7:0];
        rd(OFS_DATA_HIGH);
        chk("flash word", {rv[23:0], w}, {18'h0, i_pfsa_flash_ref.mem[a]});
        rc(OFS_CONTROL, 32'h04);
    endtask : fread
    task automatic grp(input logic [9:0] b, input logic halt);
        logic [13:0] d;
        wr(OFS_CONTROL, 8'h04);
        for (int i = 0; i < 4; i++) begin
            rv = rnd();
            d = rv[13:0];
            wr(OFS_ADDR_HIGH, {6'h0, b[9:8]});
            wr(OFS_ADDR_LOW, b[7:0] | i[7:0]);
            wr(OFS_DATA_LOW, d[7:0]);
            wr(OFS_DATA_HIGH, {2'h0, d[13:8]});
            wr(OFS_UNLOCK, KEY_FIRST);
            wr(OFS_UNLOCK, KEY_SECOND);
            wr(OFS_CONTROL, 8'h06);
            i_pfsa_flash_ref.prog(b | i[9:0], d);
            rd(OFS_CONTROL);
            chk("start bit", rv, (i == 3 && halt) ? 32'h06 : 32'h04);
            chk("halt", {31'h0, CPU_HALT}, {31'h0, (i == 3 && halt)});
            for (int n = 0; n < 40 && rv[1]; n++) rd(OFS_CONTROL);
            chk("start done", rv, 32'h04);
        end
        for (int i = 0; i < 16; i++) fread({b[9:4], i[3:0]});
    endtask : grp
    task automatic bad(input logic [7:0] pre, input logic [7:0] k1, input logic [7:0] k2);
        wr(OFS_CONTROL, pre);
        wr(OFS_UNLOCK, k1);
        wr(OFS_UNLOCK, k2);
        wr(OFS_CONTROL, 8'h06);
        // the refused start write still leaves permit set
        rc(OFS_CONTROL, 32'h04);
    endtask : bad
    task automatic restart(input logic [1:0] wps, input logic cpb);
        RST_B <= 1'b0;
        WRITE_PROTECT_SELECT <= wps;
        CODE_PROTECT_B <= cpb;
        i_pfsa_flash_ref.wps = wps;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
    endtask : restart
    initial begin
        RST_B = 1'b0;
        CE = 1'b1;
        WSTRB = 4'h1;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
        {AWADDR, ARADDR, WDATA} = 48'h0;
        restart(2'h0, 1'b1);
        foreach (offs[i]) rc(offs[i], 32'h0);
        rd(8'h18);
        chk("unmapped resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(8'h18, 8'hA5);
        for (int k = 0; k < 12; k++) begin
            rv = rnd();
            v = rv[7:0];
            lag = rv[8];
            wr(offs[k % 4], v);
            rc(offs[k % 4], {24'h0, v & msk[k % 4]});
        end
        lag = 1'b0;
        WSTRB <= 4'h0;
        wr(OFS_ADDR_HIGH, ~v);
        WSTRB <= 4'h1;
        rc(OFS_ADDR_HIGH, {24'h0, v & 8'h03});
        wr(OFS_CONTROL, 8'hFC);
        rc(OFS_CONTROL, 32'h04);
        wr(OFS_UNLOCK, KEY_FIRST);
        rc(OFS_UNLOCK, 32'h0);
        $display("test registers done");
        wr(OFS_ADDR_HIGH, 8'h03);
        wr(OFS_ADDR_LOW, 8'h03);
        bad(8'h04, KEY_SECOND, KEY_FIRST);
        bad(8'h00, KEY_FIRST, KEY_SECOND);
        bad(8'h04, KEY_FIRST, KEY_FIRST);
        fread(10'h303);
        $display("test refused starts done");
        grp(10'h300, 1'b1);
        grp(10'h304, 1'b1);
        $display("test group writes done");
        restart(2'h1, 1'b0);
        chk("programmer", {31'h0, PROGRAMMER_ALLOW}, 32'h0);
        grp(10'h000, 1'b0);
        grp(10'h3F4, 1'b1);
        $display("test protection done");
        conclude();
    end
endmodule : pfsa_ctrl_test
`default_nettype wire

/* File: sim/pfsa_flash_ref.sv */
// pfsa_flash_ref: behavioural far-side flash array, predicts what the controller stores.
// assumes the bench calls prog in the order the controller executes group writes.
`timescale 1ns/1ps
`default_nettype none
module pfsa_flash_ref;
    import pfsa_pkg::*;
    logic [WORD_W-1:0] mem [2**ADDR_W];
    logic [WORD_W-1:0] grp [GROUP_WORDS];
    logic [1:0] wps;
    initial begin
        foreach (mem[i]) mem[i] = 14'h3FFF;
        wps = 2'h0;
    end
    // buffer fill only; the row changes on the last group position
    task automatic prog(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        grp[a[1:0]] = d;
        if (a[1:0] == GROUP_LAST && a[9:8] >= wps) begin
            for (int i = 0; i < ROW_WORDS; i++) mem[{a[9:4], i[3:0]}] = 14'h3FFF;
            for (int i = 0; i < GROUP_WORDS; i++) mem[{a[9:2], i[1:0]}] = grp[i];
        end
    endtask : prog
endmodule : pfsa_flash_ref
`default_nettype wire

/* File: src/pfsa_array.sv */
// pfsa_array: the 1K x 14 program flash model, with row erase and word program.
// assumes the sequencer never reads and programs in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module pfsa_array (
    // clock
    input wire logic CLK,
    input wire logic CE,
    // read port
    input wire logic rd_en,
    input wire logic [pfsa_pkg::ADDR_W-1:0] rd_addr,
    output logic [pfsa_pkg::WORD_W-1:0] rd_data,
    // program port
    input wire logic wr_en,
    input wire pfsa_pkg::pfsa_word_type wr_word,
    input wire logic erase_en,
    input wire logic [pfsa_pkg::ADDR_W-5:0] erase_row
);
    import pfsa_pkg::*;
    // a blank part starts fully erased, so never-written words read back as ones
    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1] = '{default: '1};
    // erased flash reads as all ones
    always_ff @(posedge CLK) begin
        if (CE) begin
            if (rd_en) begin
                rd_data <= mem[rd_addr];
            end
            if (erase_en) begin
                for (int i = 0; i < ROW_WORDS; i++) begin
                    mem[{erase_row, 4'(i)}] <= '1;
                end
            end else if (wr_en) begin
                mem[wr_word.addr] <= wr_word.data;
            end
        end
    end
endmodule : pfsa_array
`default_nettype wire

/* File: src/pfsa_ctrl.sv */
// pfsa_ctrl: AXI4-Lite register front end and sequencer for flash self-read/self-write.
// assumes one clock, CPU halt consumed by the core, config bits static after reset.
`timescale 1ns/1ps
`default_nettype none
module pfsa_ctrl #(
    parameter int unsigned ERASE_COUNT = pfsa_pkg::ERASE_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    // axi4-lite write
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // configuration
    input wire logic [1:0] WRITE_PROTECT_SELECT,
    input wire logic CODE_PROTECT_B,
    // core and programmer side
    output logic CPU_HALT,
    output logic PROGRAMMER_ALLOW
);
    import pfsa_pkg::*;

    logic [7:0] data_low_q, data_low_d;
    logic [7:0] addr_low_q, addr_low_d;
    logic [5:0] data_high_q, data_high_d;
    logic [1:0] addr_high_q, addr_high_d;
    logic permit_q, permit_d;
    logic rd_start_q, rd_start_d;
    logic wr_start_q, wr_start_d;
    pfsa_unlock_type unlock_q, unlock_d;
    pfsa_seq_type seq_q, seq_d;
    logic [31:0] count_q, count_d;
    logic [1:0] group_q, group_d;
    pfsa_word_type [GROUP_WORDS-1:0] buf_q, buf_d;
    logic aw_have_q, aw_have_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic w_have_q, w_have_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic wr_fire, protected_row;
    logic [ADDR_W-1:0] word_addr;
    logic [WORD_W-1:0] arr_rd_data;
    logic arr_rd_en, arr_wr_en, arr_erase_en;
    pfsa_word_type arr_word;

    assign word_addr = {addr_high_q, addr_low_q};
    assign AWREADY = !aw_have_q;
    assign WREADY = !w_have_q;
    assign ARREADY = !rvalid_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;
    assign CPU_HALT = (seq_q == SEQ_ERASE);
    assign PROGRAMMER_ALLOW = CODE_PROTECT_B;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    // protect select: 0 none, 1 lowest quarter, 2 lower half, 3 lower three quarters
    assign protected_row = (word_addr[ADDR_W-1:ADDR_W-2] < WRITE_PROTECT_SELECT);

    // bus and register state
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        data_low_d = data_low_q;
        data_high_d = data_high_q;
        addr_low_d = addr_low_q;
        addr_high_d = addr_high_q;
        permit_d = permit_q;
        rd_start_d = rd_start_q;
        wr_start_d = wr_start_q;
        unlock_d = unlock_q;
        if (AWVALID && !aw_have_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = {AWADDR[7:2], 2'h0};
        end
        if (WVALID && !w_have_q) begin
            w_have_d = 1'b1;
            w_data_d = WDATA;
            w_strb_d = WSTRB;
        end
        if (BVALID && BREADY) begin
            bvalid_d = 1'b0;
        end
        if (RVALID && RREADY) begin
            rvalid_d = 1'b0;
        end
        // any write other than the first key, or the second key right after it, breaks the unlock chain
        if (wr_fire) begin
            unlock_d = UNLOCK_IDLE;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            if (w_strb_q[0]) begin
                case (aw_addr_q)
                    OFS_DATA_LOW: data_low_d = w_data_q[7:0];
                    OFS_DATA_HIGH: data_high_d = w_data_q[5:0];
                    OFS_ADDR_LOW: addr_low_d = w_data_q[7:0];
                    OFS_ADDR_HIGH: addr_high_d = w_data_q[1:0];
                    OFS_CONTROL: begin
                        permit_d = w_data_q[CTL_PERMIT_BIT];
                        if (w_data_q[CTL_READ_BIT] && seq_q == SEQ_IDLE) begin
                            rd_start_d = 1'b1;
                        end
                        if (w_data_q[CTL_WRITE_BIT] && permit_q && unlock_q == UNLOCK_OPEN
                                && seq_q == SEQ_IDLE && !rd_start_q) begin
                            wr_start_d = 1'b1;
                        end
                    end
                    OFS_UNLOCK: begin
                        if (w_data_q[7:0] == KEY_FIRST) begin
                            unlock_d = UNLOCK_HALF;
                        end else if (w_data_q[7:0] == KEY_SECOND && unlock_q == UNLOCK_HALF) begin
                            unlock_d = UNLOCK_OPEN;
                        end
                    end
                    default: bresp_d = RESP_SLVERR;
                endcase
            end else if (aw_addr_q > OFS_UNLOCK) begin
                bresp_d = RESP_SLVERR;
            end
        end
        if (ARVALID && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case ({ARADDR[7:2], 2'h0})
                OFS_DATA_LOW: rdata_d = {24'h000000, data_low_q};
                OFS_DATA_HIGH: rdata_d = {26'h0000000, data_high_q};
                OFS_ADDR_LOW: rdata_d = {24'h000000, addr_low_q};
                OFS_ADDR_HIGH: rdata_d = {30'h00000000, addr_high_q};
                OFS_CONTROL: rdata_d = {29'h00000000, permit_q, wr_start_q, rd_start_q};
                OFS_UNLOCK: rdata_d = 32'h00000000;
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        // sequencer effects on software-visible state
        if (seq_q == SEQ_READ_FETCH) begin
            rd_start_d = 1'b0;
            data_low_d = arr_rd_data[7:0];
            data_high_d = arr_rd_data[WORD_W-1:8];
        end
        if (seq_q == SEQ_IDLE && wr_start_q && !rd_start_q && group_q != GROUP_LAST) begin
            wr_start_d = 1'b0;
        end
        if (seq_q == SEQ_ERASE && count_q == 32'(ERASE_COUNT - 1)) begin
            wr_start_d = 1'b0;
        end
        if (seq_q == SEQ_IDLE && wr_start_q && protected_row) begin
            wr_start_d = 1'b0;
        end
    end

    // sequencer
    always_comb begin
        seq_d = seq_q;
        count_d = count_q;
        group_d = group_q;
        buf_d = buf_q;
        arr_rd_en = 1'b0;
        arr_wr_en = 1'b0;
        arr_erase_en = 1'b0;
        arr_word = buf_q[group_q];
        case (seq_q)
            SEQ_IDLE: begin
                if (rd_start_q) begin
                    seq_d = SEQ_READ_WAIT;
                end else if (wr_start_q && !protected_row) begin
                    // write lands in the buffer slot named by the low address bits
                    buf_d[addr_low_q[1:0]] = '{addr: word_addr, data: {data_high_q, data_low_q}};
                    if (addr_low_q[1:0] == GROUP_LAST) begin
                        seq_d = SEQ_ERASE;
                        count_d = 32'h00000000;
                    end
                end
            end
            SEQ_READ_WAIT: begin
                arr_rd_en = 1'b1;
                seq_d = SEQ_READ_FETCH;
            end
            SEQ_READ_FETCH: seq_d = SEQ_IDLE;
            SEQ_ERASE: begin
                count_d = count_q + 32'h00000001;
                // erase at the start, then program one buffered word a cycle at the end
                if (count_q == 32'h00000000) begin
                    arr_erase_en = 1'b1;
                end else if (count_q >= 32'(ERASE_COUNT - GROUP_WORDS)) begin
                    arr_wr_en = 1'b1;
                    arr_word = buf_q[2'(count_q - 32'(ERASE_COUNT - GROUP_WORDS))];
                end
                if (count_q == 32'(ERASE_COUNT - 1)) begin
                    seq_d = SEQ_IDLE;
                end
            end
            default: seq_d = SEQ_IDLE;
        endcase
        group_d = addr_low_q[1:0];
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= RESET_BYTE;
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
            data_low_q <= RESET_BYTE;
            data_high_q <= 6'h00;
            addr_low_q <= RESET_BYTE;
            addr_high_q <= 2'h0;
            permit_q <= 1'b0;
            rd_start_q <= 1'b0;
            wr_start_q <= 1'b0;
            unlock_q <= UNLOCK_IDLE;
            seq_q <= SEQ_IDLE;
            count_q <= 32'h00000000;
            group_q <= 2'h0;
            buf_q <= '0;
        end else if (CE) begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            data_low_q <= data_low_d;
            data_high_q <= data_high_d;
            addr_low_q <= addr_low_d;
            addr_high_q <= addr_high_d;
            permit_q <= permit_d;
            rd_start_q <= rd_start_d;
            wr_start_q <= wr_start_d;
            unlock_q <= unlock_d;
            seq_q <= seq_d;
            count_q <= count_d;
            group_q <= group_d;
            buf_q <= buf_d;
        end
    end

    pfsa_array u_array (
        .CLK(CLK),
        .CE(CE),
        .rd_en(arr_rd_en),
        .rd_addr(word_addr),
        .rd_data(arr_rd_data),
        .wr_en(arr_wr_en),
        .wr_word(arr_word),
        .erase_en(arr_erase_en),
        .erase_row(word_addr[ADDR_W-1:4])
    );
endmodule : pfsa_ctrl
`default_nettype wire

/* File: src/pfsa_pkg.sv */
// pfsa_pkg: constants and types for the program flash self-access controller.
// assumes a 32-bit AXI4-Lite register bus and a 1K x 14 flash array beside the block.
package pfsa_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned ERASE_TIME_US = 4000;
    localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * (CLK_HZ / 1_000_000);
    localparam logic [7:0] OFS_DATA_LOW = 8'h00;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h04;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h08;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_UNLOCK = 8'h14;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int unsigned CTL_READ_BIT = 0;
    localparam int unsigned CTL_WRITE_BIT = 1;
    localparam int unsigned CTL_PERMIT_BIT = 2;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned WORD_W = 14;
    localparam int unsigned GROUP_WORDS = 4;
    localparam int unsigned ROW_WORDS = 16;
    localparam logic [1:0] GROUP_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } pfsa_word_type;
    typedef enum logic [1:0] {
        UNLOCK_IDLE,
        UNLOCK_HALF,
        UNLOCK_OPEN
    } pfsa_unlock_type;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_READ_WAIT,
        SEQ_READ_FETCH,
        SEQ_ERASE
    } pfsa_seq_type;
endpackage : pfsa_pkg
